// ---- core/wdit_defines.vh ----
`ifndef WDIT_DEFINES_VH
`define WDIT_DEFINES_VH

// register addresses
`define WDIT_ADDR_W          16
`define WDIT_SEL_ADDR        16'hFF42
`define WDIT_MODE_ADDR       16'hFF43
`define WDIT_CTRL_ADDR       16'hFF44
`define WDIT_CNT_ADDR        16'hFF45

// mode register fields
`define WDIT_RUN_BIT         7
`define WDIT_MODE_SEL_BIT    4
`define WDIT_ACTION_BIT      3

// clock-select register fields
`define WDIT_CLK_SEL_HI_BIT  2
`define WDIT_CLK_SEL_LO_BIT  1

// control register fields
`define WDIT_MASK_BIT        0
`define WDIT_FLAG_BIT        1

// reset values
`define WDIT_SEL_RST         8'h00
`define WDIT_MODE_RST        8'h00
`define WDIT_MASK_RST        1'b1

// prescaler of the main clock, 2^7
`define WDIT_PRE_W           7

// count of the watchdog counter in fw ticks
`define WDIT_CNT_W           14
`define WDIT_LIM_13          14'h1FFF
`define WDIT_LIM_14          14'h3FFF

// priority level of the interval request, zero is highest
`define WDIT_IRQ_PRIO        3'h0

`endif

// ---- core/wdit_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defines.vh"

module wdit_top
(
  // clock and reset
  input  wire                     ref_clk_in,
  input  wire                     sys_rst_in,
  // register port
  input  wire [`WDIT_ADDR_W-1:0]  reg_addr_in,
  input  wire [7:0]               reg_wdata_in,
  input  wire                     reg_wr_in,
  input  wire                     reg_rd_in,
  output reg  [7:0]               reg_rdata_out,
  // count sources, one-cycle ticks
  input  wire                     main_clock_crystal_tick_in,
  input  wire                     sub_clock_tick_in,
  // processor state
  input  wire                     halt_mode_in,
  input  wire                     stop_mode_in,
  input  wire                     cpu_on_sub_clock_in,
  // overflow actions
  output reg                      sys_reset_req_out,
  output reg                      nmi_req_out,
  output reg                      interval_timer_irq_out,
  output reg  [2:0]               interval_irq_prio_out
);

  ////////////////////////////////////////////////////////////////////////
  // state

  localparam ST_IDLE     = 3'b001;
  localparam ST_INTERVAL = 3'b010;
  localparam ST_WATCHDOG = 3'b100;

  reg  [2:0]               state_r;
  reg  [2:0]               state_nxt;
  reg                      clock_select_high_r;
  reg                      clock_select_low_r;
  reg                      run_r;
  reg                      mode_select_bit_r;
  reg                      overflow_action_bit_r;
  reg                      interval_irq_mask_r;
  reg                      irq_flag_r;
  reg  [`WDIT_PRE_W-1:0]   pre_r;
  reg  [`WDIT_CNT_W-1:0]   cnt_r;
  reg  [`WDIT_CNT_W-1:0]   cnt_nxt;

  wire                     wr_sel;
  wire                     wr_mode;
  wire                     wr_ctrl;
  wire                     run_kick;
  wire                     fw_tick;
  wire                     count_en;
  wire                     ovf;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // period limit from the select field
  function [`WDIT_CNT_W-1:0] limit_of;
    input sel_lo;
    begin
      if (sel_lo)
      begin
        limit_of = `WDIT_LIM_14;
      end
      else
      begin
        limit_of = `WDIT_LIM_13;
      end
    end
  endfunction

  // address match with a write strobe
  function wr_hit;
    input                    wr;
    input [`WDIT_ADDR_W-1:0] addr;
    input [`WDIT_ADDR_W-1:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode

  assign wr_sel   = wr_hit(reg_wr_in, reg_addr_in, `WDIT_SEL_ADDR);
  assign wr_mode  = wr_hit(reg_wr_in, reg_addr_in, `WDIT_MODE_ADDR);
  assign wr_ctrl  = wr_hit(reg_wr_in, reg_addr_in, `WDIT_CTRL_ADDR);
  assign run_kick = wr_mode && reg_wdata_in[`WDIT_RUN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // count clock: main / 2^7 or subsystem direct

  // prescaler never cleared by a run write, so first period may be short
  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      pre_r <= {`WDIT_PRE_W{1'b0}};
    end
    else if (main_clock_crystal_tick_in)
    begin
      pre_r <= pre_r + 1'b1;
    end
  end

  assign fw_tick = clock_select_high_r ? sub_clock_tick_in :
                   (main_clock_crystal_tick_in && (pre_r == {`WDIT_PRE_W{1'b1}}));

  // halt has no effect on counting
  assign count_en = run_r && (state_r != ST_IDLE) && !stop_mode_in
                    && !cpu_on_sub_clock_in && fw_tick;

  assign ovf = count_en && (cnt_r == limit_of(clock_select_low_r));

  ////////////////////////////////////////////////////////////////////////
  // mode state machine

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (mode_select_bit_r)
        begin
          state_nxt = ST_WATCHDOG;
        end
        else if (overflow_action_bit_r)
        begin
          state_nxt = ST_INTERVAL;
        end
      end
      ST_INTERVAL:
      begin
        if (mode_select_bit_r)
        begin
          state_nxt = ST_WATCHDOG;
        end
      end
      ST_WATCHDOG:
      begin
        state_nxt = ST_WATCHDOG;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      clock_select_high_r   <= 1'b0;
      clock_select_low_r    <= 1'b0;
      run_r                 <= 1'b0;
      mode_select_bit_r     <= 1'b0;
      overflow_action_bit_r <= 1'b0;
      interval_irq_mask_r   <= `WDIT_MASK_RST;
    end
    else
    begin
      if (wr_sel)
      begin
        clock_select_high_r <= reg_wdata_in[`WDIT_CLK_SEL_HI_BIT];
        clock_select_low_r  <= reg_wdata_in[`WDIT_CLK_SEL_LO_BIT];
      end
      if (wr_mode)
      begin
        // sticky ones: zeros are ignored
        run_r                 <= run_r | reg_wdata_in[`WDIT_RUN_BIT];
        mode_select_bit_r     <= mode_select_bit_r
                                 | reg_wdata_in[`WDIT_MODE_SEL_BIT];
        overflow_action_bit_r <= overflow_action_bit_r
                                 | reg_wdata_in[`WDIT_ACTION_BIT];
      end
      if (wr_ctrl)
      begin
        interval_irq_mask_r <= reg_wdata_in[`WDIT_MASK_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter

  always @*
  begin
    cnt_nxt = cnt_r;
    if (run_kick)
    begin
      cnt_nxt = {`WDIT_CNT_W{1'b0}};
    end
    else if (ovf)
    begin
      cnt_nxt = {`WDIT_CNT_W{1'b0}};
    end
    else if (count_en)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      cnt_r <= {`WDIT_CNT_W{1'b0}};
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overflow actions

  // interval pending flag: set wins over write-one clear
  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      irq_flag_r <= 1'b0;
    end
    else if (ovf && (state_r == ST_INTERVAL))
    begin
      irq_flag_r <= 1'b1;
    end
    else if (wr_ctrl && reg_wdata_in[`WDIT_FLAG_BIT])
    begin
      irq_flag_r <= 1'b0;
    end
  end

  // restart in the overflow cycle counts as in time
  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      sys_reset_req_out      <= 1'b0;
      nmi_req_out            <= 1'b0;
      interval_timer_irq_out <= 1'b0;
      interval_irq_prio_out  <= `WDIT_IRQ_PRIO;
    end
    else
    begin
      sys_reset_req_out      <= ovf && !run_kick && (state_r == ST_WATCHDOG)
                                && overflow_action_bit_r;
      nmi_req_out            <= ovf && !run_kick && (state_r == ST_WATCHDOG)
                                && !overflow_action_bit_r;
      interval_timer_irq_out <= ovf && !run_kick && (state_r == ST_INTERVAL)
                                && !interval_irq_mask_r;
      interval_irq_prio_out  <= `WDIT_IRQ_PRIO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe

  always @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `WDIT_SEL_ADDR:
        begin
          reg_rdata_out <= {5'h00, clock_select_high_r, clock_select_low_r, 1'b0};
        end
        `WDIT_MODE_ADDR:
        begin
          reg_rdata_out <= {run_r, 2'h0, mode_select_bit_r, overflow_action_bit_r, 3'h0};
        end
        `WDIT_CTRL_ADDR:
        begin
          reg_rdata_out <= {6'h00, irq_flag_r, interval_irq_mask_r};
        end
        `WDIT_CNT_ADDR:
        begin
          reg_rdata_out <= cnt_r[`WDIT_CNT_W-1:`WDIT_CNT_W-8];
        end
        default:
        begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end
    else
    begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ---- bench/wdit_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defines.vh"
module wdit_chk (
  // clock and reset
  input wire logic                    ref_clk_in,
  input wire logic                    sys_rst_in,
  // register port
  input wire logic [`WDIT_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0]              reg_wdata_in,
  input wire logic                    reg_wr_in,
  input wire logic                    reg_rd_in,
  input wire logic [7:0]              reg_rdata_out,
  // state and actions
  input wire logic                    stop_mode_in,
  input wire logic                    cpu_on_sub_clock_in,
  input wire logic                    sys_reset_req_out,
  input wire logic                    nmi_req_out,
  input wire logic                    interval_timer_irq_out,
  input wire logic [2:0]              interval_irq_prio_out
);
  wire evt;
  assign evt = sys_reset_req_out | nmi_req_out | interval_timer_irq_out;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////
  a_prio_top: assert property (interval_irq_prio_out == `WDIT_IRQ_PRIO)
    else $error("irq priority not top");
  a_freeze_quiet: assert property ($past(stop_mode_in) || $past(cpu_on_sub_clock_in) |-> !evt)
    else $error("overflow while frozen");
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst_in |=> !evt && reg_rdata_out == 8'h00)
    else $error("output active after reset");
  a_sel_read: assert property ((reg_wr_in && reg_addr_in == `WDIT_SEL_ADDR) ##2
    (reg_rd_in && reg_addr_in == `WDIT_SEL_ADDR) |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h06))
    else $error("select readback wrong");
  a_mode_sticky: assert property ((reg_wr_in && reg_addr_in == `WDIT_MODE_ADDR) ##2
    (reg_rd_in && reg_addr_in == `WDIT_MODE_ADDR) |=>
    (reg_rdata_out & $past(reg_wdata_in, 3) & 8'h98) == ($past(reg_wdata_in, 3) & 8'h98))
    else $error("mode bit lost");
  a_one_pulse: assert property (evt |=> !evt)
    else $error("overflow pulse too long");
  a_one_action: assert property ($onehot0({sys_reset_req_out, nmi_req_out, interval_timer_irq_out}))
    else $error("two actions at once");
  a_kick_quiet: assert property (reg_wr_in && reg_addr_in == `WDIT_MODE_ADDR && reg_wdata_in[7] |=> !evt [*8])
    else $error("overflow right after restart");
  c_reset: cover property (sys_reset_req_out);
  c_nmi: cover property (nmi_req_out);
  c_irq: cover property (interval_timer_irq_out);
endmodule
bind wdit_top wdit_chk u_chk (.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .stop_mode_in, .cpu_on_sub_clock_in, .sys_reset_req_out, .nmi_req_out,
  .interval_timer_irq_out, .interval_irq_prio_out);
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdit_defines.vh"
module tb;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        halt_mode_in = 1'b0;
  logic        stop_mode_in = 1'b0;
  logic        cpu_on_sub_clock_in = 1'b0;
  logic        main_clock_crystal_tick_in = 1'b0;
  logic        sub_clock_tick_in = 1'b1;
  logic [7:0]  reg_rdata_out;
  logic        sys_reset_req_out;
  logic        nmi_req_out;
  logic        interval_timer_irq_out;
  logic [2:0]  interval_irq_prio_out;
  logic [2:0]  evs;
  int          errors = 0;
  int          n_tests = 0;
  int          n;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} wdit_row_t;
  wdit_row_t   rows [6] = '{'{`WDIT_SEL_ADDR, 8'hff, 8'h06}, '{`WDIT_SEL_ADDR, 8'h02, 8'h02},
    '{`WDIT_CTRL_ADDR, 8'h00, 8'h00}, '{`WDIT_CNT_ADDR, 8'hff, 8'h00}, '{16'hff40, 8'hff, 8'h00},
    '{`WDIT_MODE_ADDR, 8'h00, 8'h00}};
  assign evs = {interval_timer_irq_out, nmi_req_out, sys_reset_req_out};
  // sub clock ticks every cycle, main ticks only in the last case
  wdit_top u_dut (.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .main_clock_crystal_tick_in, .sub_clock_tick_in, .halt_mode_in,
    .stop_mode_in, .cpu_on_sub_clock_in, .sys_reset_req_out, .nmi_req_out, .interval_timer_irq_out,
    .interval_irq_prio_out);
  initial
  begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task finish_test;
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task do_reset;
    sys_rst_in <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    chk({8'h00, reg_rdata_out}, {8'h00, e});
  endtask
  // counts edges until the chosen action shows, at most lim
  task wait_ev(input int s, input int lim);
    n = 0;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end while (n < lim && evs[s] !== 1'b1);
  endtask
  task in_rng(input int lo, input int hi);
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge ref_clk_in);
    errors++;
    finish_test;
  end
  initial
  begin
    do_reset;
    rd(`WDIT_SEL_ADDR, 8'h00);
    rd(`WDIT_MODE_ADDR, 8'h00);
    rd(`WDIT_CTRL_ADDR, 8'h01);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(`WDIT_SEL_ADDR, 8'h04);
    halt_mode_in <= 1'b1;
    wr(`WDIT_MODE_ADDR, 8'h08);
    wait_ev(2, 8400);
    chk(16'(n), 16'd8400);
    wr(`WDIT_MODE_ADDR, 8'h88);
    wait_ev(2, 9000);
    in_rng(8185, 8200);
    wait_ev(2, 9000);
    in_rng(8190, 8194);
    wr(`WDIT_CTRL_ADDR, 8'h01);
    wait_ev(2, 8400);
    chk(16'(n), 16'd8400);
    rd(`WDIT_CTRL_ADDR, 8'h03);
    wr(`WDIT_CTRL_ADDR, 8'h03);
    rd(`WDIT_CTRL_ADDR, 8'h01);
    do_reset;
    wr(`WDIT_SEL_ADDR, 8'h04);
    wr(`WDIT_MODE_ADDR, 8'h98);
    wait_ev(0, 6000);
    chk(16'(n), 16'd6000);
    wr(`WDIT_MODE_ADDR, 8'h80);
    rd(`WDIT_MODE_ADDR, 8'h98);
    stop_mode_in <= 1'b1;
    repeat (3000) @(posedge ref_clk_in);
    stop_mode_in <= 1'b0;
    wait_ev(0, 9000);
    in_rng(8180, 8200);
    do_reset;
    wr(`WDIT_SEL_ADDR, 8'h06);
    wr(`WDIT_MODE_ADDR, 8'h90);
    cpu_on_sub_clock_in <= 1'b1;
    repeat (1000) @(posedge ref_clk_in);
    cpu_on_sub_clock_in <= 1'b0;
    wait_ev(1, 18000);
    in_rng(16383, 16387);
    chk({13'h0000, interval_irq_prio_out}, {13'h0000, `WDIT_IRQ_PRIO});
    // main ticks every cycle: one count per 128 cycles, about 93 counts
    main_clock_crystal_tick_in <= 1'b1;
    do_reset;
    wr(`WDIT_MODE_ADDR, 8'h88);
    repeat (12000) @(posedge ref_clk_in);
    rd(`WDIT_CNT_ADDR, 8'h01);
    finish_test;
  end
endmodule
`default_nettype wire
